// [rtl/uart_mode_status_control.sv]
// Mode, receive error and transmit status registers of the serial core
// Functional notes
// - Power off resets statuses, break bits and receive buffer.
// - Transmit enable low resets transmitter; high enables it.
// - Receive enable low resets receiver; high enables it.
// - Power off forces mark on transmit line and high receive view.
// - Parity field: none, zero, odd or even, both directions.
// - Zero parity is never checked by the receiver.
// - Length bit picks seven or eight data bits.
// - Stop setting gives one or two transmit stop bits only.
// - Routing bit picks error or normal interrupt for receive errors.
// - Low receive line at enable starts reception at once.
// - Error status clears on reset, power or receive off, and read.
// - Parity error flag sets on parity mismatch.
// - Framing error flag sets when first stop bit is low.
// - Overrun sets on completion with unread buffer; byte discarded.
// - Transmit status clears on reset, power or transmit off.
// - Buffer full sets on buffer write, clears on move to shifter.
// - Shift busy sets on move to shifter, clears when nothing follows.
// - Writing the transmit buffer starts transmission.
`default_nettype none
module uart_mode_status_control #(
    parameter int DIV_W = 8,
    parameter logic [DIV_W-1:0] BAUD_DIV = uart_ctl_pkg::BAUD_DIV_DEFAULT
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire uart_ctl_pkg::bus_req_t req_i,
    output logic [7:0]                  rdata_o,
    input  wire logic                   receive_line_i,
    input  wire logic                   output_level_invert_i,
    output logic                        transmit_line_o,
    output logic                        receive_complete_interrupt_o,
    output logic                        receive_error_interrupt_o,
    output logic                        transmit_complete_interrupt_o,
    output logic                        break_clear_o
);
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_CHAIN = 2'b11
    } tx_state_t;

    uart_ctl_pkg::mode_t mode_r, mode_nxt;
    logic [2:0]  rx_err_r, rx_err_nxt;
    logic [7:0]  tx_buf_r, tx_buf_nxt;
    logic [7:0]  rx_buf_r, rx_buf_nxt;
    logic        rx_full_r, rx_full_nxt;
    logic        buf_full_r, buf_full_nxt;
    tx_state_t   tx_state_r, tx_state_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        rc_int_r, rc_int_nxt;
    logic        re_int_r, re_int_nxt;
    logic        tc_int_r, tc_int_nxt;

    logic        core_clr;
    logic        tx_clr;
    logic        rx_clr;
    logic        tx_load;
    logic        tx_busy;
    logic        tx_done;
    logic        tx_line;
    logic        rx_view;
    logic        rx_done;
    logic [7:0]  rx_data;
    logic        rx_pe;
    logic        rx_fe;
    logic        rx_error;

    function automatic logic hit(input uart_ctl_pkg::bus_req_t r, input logic [15:0] a);
        hit = (r.addr == a);
    endfunction : hit

    always_comb begin
        core_clr = rst_i | ~mode_r.power_bit;
        tx_clr   = core_clr | ~mode_r.transmit_enable;
        rx_clr   = core_clr | ~mode_r.receive_enable;
        rx_view  = mode_r.power_bit ? receive_line_i : 1'b1;
        tx_load  = buf_full_r && !tx_busy && !tx_clr;
    end

    uart_tx_shift #(
        .DIV_W  (DIV_W)
    ) u_tx (
        .clk_i  (clk_i),
        .clr_i  (tx_clr),
        .div_i  (BAUD_DIV),
        .load_i (tx_load),
        .data_i (tx_buf_r),
        .mode_i (mode_r),
        .busy_o (tx_busy),
        .done_o (tx_done),
        .line_o (tx_line)
    );

    uart_rx_shift #(
        .DIV_W       (DIV_W)
    ) u_rx (
        .clk_i       (clk_i),
        .clr_i       (rx_clr),
        .div_i       (BAUD_DIV),
        .line_i      (rx_view),
        .mode_i      (mode_r),
        .done_o      (rx_done),
        .data_o      (rx_data),
        .par_err_o   (rx_pe),
        .frame_err_o (rx_fe)
    );

    // Mode register
    always_comb begin
        mode_nxt = mode_r;
        if (rst_i) begin
            mode_nxt = uart_ctl_pkg::MODE_RESET;
        end else if (req_i.wr && hit(req_i, uart_ctl_pkg::MODE_ADDR)) begin
            mode_nxt = req_i.wdata;
        end
    end

    // Receive buffer, flags, interrupts
    always_comb begin
        rx_err_nxt  = rx_err_r;
        rx_buf_nxt  = rx_buf_r;
        rx_full_nxt = rx_full_r;
        rc_int_nxt  = 1'b0;
        re_int_nxt  = 1'b0;
        rx_error    = 1'b0;
        if (core_clr) begin
            rx_err_nxt  = uart_ctl_pkg::STATUS_RESET[2:0];
            rx_buf_nxt  = uart_ctl_pkg::BUF_RESET;
            rx_full_nxt = 1'b0;
        end else if (rx_clr) begin
            rx_err_nxt  = uart_ctl_pkg::STATUS_RESET[2:0];
            rx_full_nxt = 1'b0;
        end else begin
            // Set wins over a same-cycle read clear
            if (req_i.rd && hit(req_i, uart_ctl_pkg::RX_ERR_ADDR)) begin
                rx_err_nxt = 3'b000;
            end
            if (req_i.rd && hit(req_i, uart_ctl_pkg::RX_BUF_ADDR)) begin
                rx_full_nxt = 1'b0;
            end
            if (rx_done) begin
                rx_error = rx_pe | rx_fe | rx_full_r;
                rx_err_nxt[uart_ctl_pkg::PARITY_ERR_POS]  = rx_err_nxt[2] | rx_pe;
                rx_err_nxt[uart_ctl_pkg::FRAMING_ERR_POS] = rx_err_nxt[1] | rx_fe;
                if (rx_full_r) begin
                    rx_err_nxt[uart_ctl_pkg::OVERRUN_POS] = 1'b1;
                end else begin
                    rx_buf_nxt  = rx_data;
                    rx_full_nxt = 1'b1;
                end
                // Exactly one receive interrupt
                if (rx_error && !mode_r.error_interrupt_routing_bit) begin
                    re_int_nxt = 1'b1;
                end else begin
                    rc_int_nxt = 1'b1;
                end
            end
        end
    end

    // Transmit buffer, flags, interrupt
    always_comb begin
        tx_buf_nxt   = tx_buf_r;
        buf_full_nxt = buf_full_r;
        tx_state_nxt = tx_state_r;
        tc_int_nxt   = 1'b0;
        if (rst_i) begin
            tx_buf_nxt = uart_ctl_pkg::BUF_RESET;
        end
        if (tx_clr) begin
            buf_full_nxt = 1'b0;
            tx_state_nxt = TX_IDLE;
        end else begin
            if (tx_load) begin
                buf_full_nxt = 1'b0;
            end
            if (req_i.wr && hit(req_i, uart_ctl_pkg::TX_BUF_ADDR)) begin
                tx_buf_nxt   = req_i.wdata;
                buf_full_nxt = 1'b1;
            end
            if (tx_done) begin
                tc_int_nxt = 1'b1;
            end
            case (tx_state_r)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_nxt = TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_done) begin
                        tx_state_nxt = buf_full_r ? TX_CHAIN : TX_IDLE;
                    end
                end
                TX_CHAIN: begin
                    tx_state_nxt = TX_SHIFT;
                end
                default: tx_state_nxt = TX_IDLE;
            endcase
        end
    end

    // Unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (req_i.rd) begin
            case (req_i.addr)
                uart_ctl_pkg::MODE_ADDR:    rdata_nxt = mode_r;
                uart_ctl_pkg::RX_ERR_ADDR:  rdata_nxt = {5'h00, rx_err_r};
                uart_ctl_pkg::TX_STAT_ADDR: rdata_nxt = {6'h00, buf_full_r, tx_state_r != TX_IDLE};
                uart_ctl_pkg::TX_BUF_ADDR:  rdata_nxt = tx_buf_r;
                uart_ctl_pkg::RX_BUF_ADDR:  rdata_nxt = rx_buf_r;
                default:                    rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        mode_r     <= mode_nxt;
        rx_err_r   <= rx_err_nxt;
        rx_buf_r   <= rx_buf_nxt;
        rx_full_r  <= rx_full_nxt;
        tx_buf_r   <= tx_buf_nxt;
        buf_full_r <= buf_full_nxt;
        tx_state_r <= tx_state_nxt;
        rdata_r    <= rdata_nxt;
        rc_int_r   <= rc_int_nxt;
        re_int_r   <= re_int_nxt;
        tc_int_r   <= tc_int_nxt;
    end

    // Power-off forces mark before the inversion
    assign transmit_line_o = (mode_r.power_bit ? tx_line : 1'b1) ^ output_level_invert_i;
    assign rdata_o                       = rdata_r;
    assign receive_complete_interrupt_o  = rc_int_r;
    assign receive_error_interrupt_o     = re_int_r;
    assign transmit_complete_interrupt_o = tc_int_r;
    assign break_clear_o                 = core_clr;
endmodule : uart_mode_status_control
`default_nettype wire

// [shared/uart_ctl_pkg.sv]
// Register map, field positions and carrier types of the serial core
`default_nettype none
package uart_ctl_pkg;
    localparam logic [15:0] MODE_ADDR      = 16'hff50;
    localparam logic [15:0] RX_ERR_ADDR    = 16'hff53;
    localparam logic [15:0] TX_STAT_ADDR   = 16'hff55;
    localparam logic [15:0] TX_BUF_ADDR    = 16'hff59;
    localparam logic [15:0] RX_BUF_ADDR    = 16'hff5a;
    localparam logic [7:0]  MODE_RESET     = 8'h01;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  BUF_RESET      = 8'hff;
    localparam int          POWER_POS      = 7;
    localparam int          TX_EN_POS      = 6;
    localparam int          RX_EN_POS      = 5;
    localparam int          PARITY_HI_POS  = 4;
    localparam int          PARITY_LO_POS  = 3;
    localparam int          CHAR_LEN_POS   = 2;
    localparam int          STOP_POS       = 1;
    localparam int          ROUTING_POS    = 0;
    localparam int          PARITY_ERR_POS = 2;
    localparam int          FRAMING_ERR_POS = 1;
    localparam int          OVERRUN_POS    = 0;
    localparam int          BUF_FULL_POS   = 1;
    localparam int          SHIFT_BUSY_POS = 0;
    localparam logic [7:0]  BAUD_DIV_DEFAULT = 8'h10;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD  = 2'b10,
        PAR_EVEN = 2'b11
    } parity_mode_t;

    typedef struct packed {
        logic         power_bit;
        logic         transmit_enable;
        logic         receive_enable;
        parity_mode_t parity;
        logic         character_length_bit;
        logic         stop_bit_setting;
        logic         error_interrupt_routing_bit;
    } mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;
endpackage : uart_ctl_pkg
`default_nettype wire

// [rtl/uart_tx_shift.sv]
// Transmit shifter: start, data, optional parity, one or two stop bits
`default_nettype none
module uart_tx_shift #(
    parameter int DIV_W = 8
) (
    input  wire logic                 clk_i,
    input  wire logic                 clr_i,
    input  wire logic [DIV_W-1:0]     div_i,
    input  wire logic                 load_i,
    input  wire logic [7:0]           data_i,
    input  wire uart_ctl_pkg::mode_t  mode_i,
    output logic                      busy_o,
    output logic                      done_o,
    output logic                      line_o
);
    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic [11:0]      sh_r, sh_nxt;
    logic [3:0]       left_r, left_nxt;
    logic             line_r, line_nxt;
    logic             done_r, done_nxt;
    logic             par;
    logic [3:0]       nbits;
    logic [3:0]       pidx;

    always_comb begin
        par = mode_i.character_length_bit ? ^data_i : ^data_i[6:0];
        pidx = 4'd7 + {3'd0, mode_i.character_length_bit};
        nbits = 4'd8 + {3'd0, mode_i.character_length_bit}
              + {3'd0, mode_i.parity != uart_ctl_pkg::PAR_NONE}
              + {3'd0, mode_i.stop_bit_setting};
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        left_nxt = left_r;
        line_nxt = line_r;
        done_nxt = 1'b0;
        if (clr_i) begin
            cnt_nxt  = '0;
            left_nxt = '0;
            line_nxt = 1'b1;
        end else if (load_i && left_r == 4'd0) begin
            sh_nxt = {4'hf, mode_i.character_length_bit ? data_i[7] : 1'b1, data_i[6:0]};
            case (mode_i.parity)
                uart_ctl_pkg::PAR_ZERO: sh_nxt[pidx] = 1'b0;
                uart_ctl_pkg::PAR_ODD:  sh_nxt[pidx] = ~par;
                uart_ctl_pkg::PAR_EVEN: sh_nxt[pidx] = par;
                default: ;
            endcase
            line_nxt = 1'b0;
            left_nxt = nbits + 4'd1;
            cnt_nxt  = div_i;
        end else if (left_r != 4'd0) begin
            if (cnt_r == '0) begin
                cnt_nxt  = div_i;
                line_nxt = sh_r[0];
                sh_nxt   = {1'b1, sh_r[11:1]};
                left_nxt = left_r - 4'd1;
                done_nxt = (left_r == 4'd1);
            end else begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        cnt_r  <= cnt_nxt;
        sh_r   <= sh_nxt;
        left_r <= left_nxt;
        line_r <= line_nxt;
        done_r <= done_nxt;
    end

    assign busy_o = (left_r != 4'd0);
    assign done_o = done_r;
    assign line_o = line_r;
endmodule : uart_tx_shift
`default_nettype wire

// [rtl/uart_rx_shift.sv]
// Receive shifter: samples mid-bit, one stop bit, reports parity and framing
`default_nettype none
module uart_rx_shift #(
    parameter int DIV_W = 8
) (
    input  wire logic                 clk_i,
    input  wire logic                 clr_i,
    input  wire logic [DIV_W-1:0]     div_i,
    input  wire logic                 line_i,
    input  wire uart_ctl_pkg::mode_t  mode_i,
    output logic                      done_o,
    output logic [7:0]                data_o,
    output logic                      par_err_o,
    output logic                      frame_err_o
);
    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic [9:0]       sh_r, sh_nxt;
    logic [3:0]       left_r, left_nxt;
    logic             done_r, done_nxt;
    logic [7:0]       data_r, data_nxt;
    logic             pe_r, pe_nxt;
    logic             fe_r, fe_nxt;
    logic [3:0]       nbits;
    logic [9:0]       al;
    logic             p;
    logic [3:0]       pidx;
    logic             arm_r, arm_nxt;

    always_comb begin
        nbits = 4'd8 + {3'd0, mode_i.character_length_bit}
              + {3'd0, mode_i.parity != uart_ctl_pkg::PAR_NONE};
        pidx     = 4'd7 + {3'd0, mode_i.character_length_bit};
        arm_nxt  = arm_r;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        left_nxt = left_r;
        done_nxt = 1'b0;
        data_nxt = data_r;
        pe_nxt   = pe_r;
        fe_nxt   = fe_r;
        al = sh_r >> (4'd10 - nbits);
        p  = mode_i.character_length_bit ? ^al[7:0] : ^al[6:0];
        if (clr_i) begin
            cnt_nxt  = '0;
            left_nxt = '0;
            arm_nxt  = 1'b1;
        end else if (left_r == 4'd0) begin
            // Low line at enable starts a frame at once
            arm_nxt = arm_r | line_i;
            if (!line_i && arm_r) begin
                left_nxt = nbits;
                cnt_nxt  = div_i + (div_i >> 1);
            end
        end else if (cnt_r == '0) begin
            sh_nxt   = {line_i, sh_r[9:1]};
            cnt_nxt  = div_i;
            left_nxt = left_r - 4'd1;
            if (left_r == 4'd1) begin
                // Only the first stop bit is looked at
                al = sh_nxt >> (4'd10 - nbits);
                p  = mode_i.character_length_bit ? ^al[7:0] : ^al[6:0];
                done_nxt = 1'b1;
                data_nxt = mode_i.character_length_bit ? al[7:0] : {1'b0, al[6:0]};
                fe_nxt   = ~line_i;
                // Rearm only once the line is high
                arm_nxt  = line_i;
                case (mode_i.parity)
                    uart_ctl_pkg::PAR_ODD:  pe_nxt = ~(p ^ al[pidx]);
                    uart_ctl_pkg::PAR_EVEN: pe_nxt = p ^ al[pidx];
                    default:                pe_nxt = 1'b0;
                endcase
            end
        end else begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        cnt_r  <= cnt_nxt;
        sh_r   <= sh_nxt;
        left_r <= left_nxt;
        done_r <= done_nxt;
        data_r <= data_nxt;
        pe_r   <= pe_nxt;
        fe_r   <= fe_nxt;
        arm_r  <= arm_nxt;
    end

    assign done_o      = done_r;
    assign data_o      = data_r;
    assign par_err_o   = pe_r;
    assign frame_err_o = fe_r;
endmodule : uart_rx_shift
`default_nettype wire

// [sim/uart_mode_status_control_props.sv]
// Assertions on the serial core's pins
`default_nettype none
module uart_mode_status_control_props #(
    parameter int               DIV_W    = 8,
    parameter logic [DIV_W-1:0] BAUD_DIV = uart_ctl_pkg::BAUD_DIV_DEFAULT
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire uart_ctl_pkg::bus_req_t req_i,
    input wire logic [7:0]             rdata_o,
    input wire logic                   receive_line_i,
    input wire logic                   output_level_invert_i,
    input wire logic                   transmit_line_o,
    input wire logic                   receive_complete_interrupt_o,
    input wire logic                   receive_error_interrupt_o,
    input wire logic                   transmit_complete_interrupt_o,
    input wire logic                   break_clear_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] mode_r, mode_nxt;
    logic       txact_r, txact_nxt;
    logic       mode_wr, buf_wr, off_rd;
    assign mode_wr = req_i.wr && req_i.addr == uart_ctl_pkg::MODE_ADDR;
    assign buf_wr  = req_i.wr && req_i.addr == uart_ctl_pkg::TX_BUF_ADDR;
    assign off_rd  = req_i.rd && !mode_r[7] && (req_i.addr == uart_ctl_pkg::RX_ERR_ADDR ||
                     req_i.addr == uart_ctl_pkg::TX_STAT_ADDR);
    // Mode shadow; coarse busy tracking, so only first bytes are judged
    always_comb begin
        mode_nxt  = mode_wr ? req_i.wdata : mode_r;
        txact_nxt = (txact_r || buf_wr) && !transmit_complete_interrupt_o &&
                    !(mode_wr && !(req_i.wdata[7] && req_i.wdata[6]));
        if (rst_i) begin
            mode_nxt  = uart_ctl_pkg::MODE_RESET;
            txact_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        mode_r  <= mode_nxt;
        txact_r <= txact_nxt;
    end
    property p_brk_on;
        mode_wr && !req_i.wdata[7] |-> ##[1:2] break_clear_o;
    endproperty
    a_brk_on: assert property (p_brk_on) else $error("break clear not raised");
    property p_brk_off;
        mode_wr && req_i.wdata[7] |-> ##[1:2] !break_clear_o;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("break clear stuck");
    property p_off_stat;
        off_rd |=> rdata_o == 8'h00;
    endproperty
    a_off_stat: assert property (p_off_stat) else $error("status not cleared");
    property p_mode_rd;
        req_i.rd && req_i.addr == uart_ctl_pkg::MODE_ADDR |=> rdata_o == mode_r;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
    property p_line_off;
        break_clear_o && $past(break_clear_o) && !output_level_invert_i |-> transmit_line_o;
    endproperty
    a_line_off: assert property (p_line_off) else $error("line not high");
    property p_tx_start;
        buf_wr && mode_r[7] && mode_r[6] && !txact_r && !output_level_invert_i
            |-> ##[1:3] (!transmit_line_o) [*4];
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_int_excl;
        !(receive_complete_interrupt_o && receive_error_interrupt_o);
    endproperty
    a_int_excl: assert property (p_int_excl) else $error("both rx interrupts");
    property p_tc_pulse;
        transmit_complete_interrupt_o |=> !transmit_complete_interrupt_o;
    endproperty
    a_tc_pulse: assert property (p_tc_pulse) else $error("tx interrupt long");
    property p_off_no_int;
        break_clear_o && $past(break_clear_o) |-> !(receive_complete_interrupt_o ||
            receive_error_interrupt_o || transmit_complete_interrupt_o);
    endproperty
    a_off_no_int: assert property (p_off_no_int) else $error("interrupt when off");
    property p_err_hi;
        req_i.rd && req_i.addr == uart_ctl_pkg::RX_ERR_ADDR |=> rdata_o[7:3] == 5'h00;
    endproperty
    a_err_hi: assert property (p_err_hi) else $error("error high bits set");
    c_tx: cover property (buf_wr ##[1:3] !transmit_line_o);
    c_rx_err: cover property (receive_error_interrupt_o);
    c_rx_ok: cover property (receive_complete_interrupt_o);
endmodule : uart_mode_status_control_props
bind uart_mode_status_control uart_mode_status_control_props #(
    .DIV_W(DIV_W), .BAUD_DIV(BAUD_DIV)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .receive_line_i(receive_line_i), .output_level_invert_i(output_level_invert_i),
    .transmit_line_o(transmit_line_o),
    .receive_complete_interrupt_o(receive_complete_interrupt_o),
    .receive_error_interrupt_o(receive_error_interrupt_o),
    .transmit_complete_interrupt_o(transmit_complete_interrupt_o),
    .break_clear_o(break_clear_o));
`default_nettype wire

// [sim/uart_peer.sv]
// Remote serial transceiver model on the core's line pins
`default_nettype none
module uart_peer #(
    parameter int BIT_T = 5
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output var  logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'b1;
    task automatic bit_out(input logic b);
        @(posedge clk_i);
        line_o <= b;
        repeat (BIT_T - 1) @(posedge clk_i);
    endtask : bit_out
    task automatic send(input logic [7:0] d, input int n, input logic [1:0] pm,
                        input logic bad_par, bad_stop);
        logic par;
        par = (n == 7) ? ^d[6:0] : ^d;
        if (pm == 2'b01) par = 1'b0;
        else if (pm == 2'b10) par = ~par;
        bit_out(1'b0);
        for (int i = 0; i < n; i++) bit_out(d[i]);
        if (pm != 2'b00) bit_out(par ^ bad_par);
        bit_out(~bad_stop);
        // Trailing mark so the receiver rearms
        bit_out(1'b1);
    endtask : send
    task automatic recv(input int n, input logic par_on, output logic [7:0] d,
                        output logic p, s2);
        d = 8'h00;
        p = 1'b0;
        @(negedge line_i);
        repeat (BIT_T / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_T) @(posedge clk_i);
            d[i] = line_i;
        end
        if (par_on) begin
            repeat (BIT_T) @(posedge clk_i);
            p = line_i;
        end
        repeat (BIT_T * 2) @(posedge clk_i);
        s2 = line_i;
    endtask : recv
endmodule : uart_peer
`default_nettype wire

// [sim/uart_mode_status_control_test.sv]
// Bench for the serial mode and status core
`default_nettype none
module uart_mode_status_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          BIT_T = 5;
    localparam logic [15:0] A_MOD = uart_ctl_pkg::MODE_ADDR;
    localparam logic [15:0] A_ERR = uart_ctl_pkg::RX_ERR_ADDR;
    localparam logic [15:0] A_TXS = uart_ctl_pkg::TX_STAT_ADDR;
    localparam logic [15:0] A_TXB = uart_ctl_pkg::TX_BUF_ADDR;
    localparam logic [15:0] A_RXB = uart_ctl_pkg::RX_BUF_ADDR;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    uart_ctl_pkg::bus_req_t req_r = '0;
    logic [7:0]             rdata;
    wire logic              rx_line;
    wire logic              tx_line;
    logic                   inv_r = 1'b0;
    logic                   rc, re, tc, brk;
    int                     errors = 0, checks = 0;
    int                     rc_n = 0, re_n = 0, tc_n = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rc === 1'b1) rc_n++;
        if (re === 1'b1) re_n++;
        if (tc === 1'b1) tc_n++;
    end
    uart_mode_status_control #(.DIV_W(8), .BAUD_DIV(8'h04)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req_r), .rdata_o(rdata),
        .receive_line_i(rx_line), .output_level_invert_i(inv_r), .transmit_line_o(tx_line),
        .receive_complete_interrupt_o(rc), .receive_error_interrupt_o(re),
        .transmit_complete_interrupt_o(tc), .break_clear_o(brk));
    uart_peer #(.BIT_T(BIT_T)) u_peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_r.addr <= a;
        req_r.wdata <= d;
        req_r.wr <= 1'b1;
        @(posedge clk_i);
        req_r.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        req_r.addr <= a;
        req_r.rd <= 1'b1;
        @(posedge clk_i);
        req_r.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    task automatic give_verdict();
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic t_reset();
        rd(A_MOD, uart_ctl_pkg::MODE_RESET);
        rd(A_ERR, 8'h00);
        rd(A_TXS, 8'h00);
        rd(16'hff51, 8'h00);
    endtask : t_reset
    task automatic t_tx();
        logic [7:0] d;
        logic       p, s2;
        wr(A_MOD, 8'h80);
        wr(A_MOD, 8'hde);
        repeat (2) @(posedge clk_i);
        fork
            begin
                u_peer.recv(8, 1'b1, d, p, s2);
                chk(d, 8'ha5);
                chk({7'h00, p}, 8'h00);
                chk({7'h00, s2}, 8'h01);
                u_peer.recv(8, 1'b1, d, p, s2);
                chk(d, 8'h3c);
            end
            begin
                wr(A_TXB, 8'ha5);
                rd(A_TXS, 8'h01);
                wr(A_TXB, 8'h3c);
                rd(A_TXS, 8'h03);
            end
        join
        repeat (3 * BIT_T) @(posedge clk_i);
        chk(8'(tc_n), 8'h02);
        rd(A_TXS, 8'h00);
        wr(A_TXB, 8'h81);
        repeat (3 * BIT_T) @(posedge clk_i);
        wr(A_MOD, 8'h9e);
        rd(A_TXS, 8'h00);
        chk({7'h00, tx_line}, 8'h01);
    endtask : t_tx
    task automatic t_rx();
        int rc0, re0;
        wr(A_MOD, 8'h90);
        wr(A_MOD, 8'hb0);
        u_peer.send(8'hd5, 7, 2'b10, 1'b0, 1'b0);
        rd(A_ERR, 8'h00);
        rd(A_RXB, 8'h55);
        u_peer.send(8'h12, 7, 2'b10, 1'b1, 1'b0);
        rd(A_ERR, 8'h04);
        rd(A_ERR, 8'h00);
        chk(8'(re_n), 8'h01);
        chk(8'(rc_n), 8'h01);
        rd(A_RXB, 8'h12);
        u_peer.send(8'h34, 7, 2'b10, 1'b0, 1'b1);
        rd(A_ERR, 8'h02);
        rd(A_RXB, 8'h34);
        u_peer.send(8'h56, 7, 2'b10, 1'b0, 1'b0);
        u_peer.send(8'h67, 7, 2'b10, 1'b0, 1'b0);
        rd(A_ERR, 8'h01);
        rd(A_RXB, 8'h56);
        u_peer.send(8'h21, 7, 2'b10, 1'b1, 1'b0);
        rd(A_RXB, 8'h21);
        wr(A_MOD, 8'h90);
        rd(A_ERR, 8'h00);
        wr(A_MOD, 8'h8d);
        repeat (2) @(posedge clk_i);
        wr(A_MOD, 8'had);
        rc0 = rc_n;
        re0 = re_n;
        u_peer.send(8'h9a, 8, 2'b01, 1'b1, 1'b0);
        rd(A_ERR, 8'h00);
        rd(A_RXB, 8'h9a);
        u_peer.send(8'hc3, 8, 2'b01, 1'b0, 1'b1);
        rd(A_ERR, 8'h02);
        chk(8'(rc_n - rc0), 8'h02);
        chk(8'(re_n - re0), 8'h00);
    endtask : t_rx
    task automatic t_power();
        wr(A_MOD, 8'hed);
        repeat (2) @(posedge clk_i);
        u_peer.send(8'h6b, 8, 2'b01, 1'b0, 1'b0);
        wr(A_TXB, 8'h0f);
        repeat (2 * BIT_T) @(posedge clk_i);
        wr(A_MOD, 8'h8d);
        wr(A_MOD, 8'h0d);
        @(posedge clk_i);
        #1 chk({7'h00, brk}, 8'h01);
        chk({7'h00, tx_line}, 8'h01);
        rd(A_RXB, uart_ctl_pkg::BUF_RESET);
        rd(A_TXS, 8'h00);
        @(posedge clk_i);
        inv_r <= 1'b1;
        @(posedge clk_i);
        #1 chk({7'h00, tx_line}, 8'h00);
    endtask : t_power
    // Whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_power();
        give_verdict();
    end
endmodule : uart_mode_status_control_test
`default_nettype wire
